// [itdt_pkg.sv]
// Constants, field layouts and carrier types of the interrupt-triggered transfer controller
package itdt_pkg;
   localparam int CH_IDX_W = 3;
   localparam int REG_AW = 12;

   // Global register byte addresses
   localparam logic [11:0] OFS_VECTOR_BASE = 12'h000;
   localparam logic [11:0] OFS_INDEX_BASE = 12'h004;
   localparam logic [11:0] OFS_OP_CTRL = 12'h008;
   localparam logic [11:0] OFS_SEQ_ENABLE = 12'h00C;
   localparam logic [11:0] OFS_DISP = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   // Channel window: base plus channel times stride, then the word below
   localparam logic [3:0] CH_WIN_TAG = 4'h1;
   localparam int CH_SEL_LSB = 5;
   localparam logic [4:0] CH_MODE_A = 5'h00;
   localparam logic [4:0] CH_MODE_B = 5'h04;
   localparam logic [4:0] CH_MODE_C = 5'h08;
   localparam logic [4:0] CH_SRC = 5'h0C;
   localparam logic [4:0] CH_DST = 5'h10;
   localparam logic [4:0] CH_CRA = 5'h14;
   localparam logic [4:0] CH_CRB = 5'h18;

   // transfer_mode_a fields
   localparam int MA_WB_DISABLE = 0;
   localparam int MA_DISP_EN = 1;
   localparam int MA_SIZE_LSB = 2;
   localparam int MA_SRC_AM_LSB = 4;
   localparam int MA_MODE_LSB = 6;
   // transfer_mode_b fields
   localparam int MB_SEQ_END = 0;
   localparam int MB_INDEX_REF = 1;
   localparam int MB_CHAIN_SEL = 2;
   localparam int MB_RPT_SRC = 3;
   localparam int MB_DST_AM_LSB = 4;
   localparam int MB_IRQ_EACH = 6;
   localparam int MB_CHAIN_EN = 7;
   // transfer_mode_c fields
   localparam int MC_FORWARD = 0;
   // operation_control and sequence_enable fields
   localparam int OC_STOP = 0;
   localparam int OC_SHORT = 1;
   localparam int OC_READ_SKIP = 2;
   localparam int SQ_EN = 0;
   localparam int SQ_TRIG_LSB = 8;

   localparam int VBR_SIGN_BIT = 27;
   localparam int VBR_ZERO_W = 10;
   localparam int SHORT_SIGN_BIT = 23;
   localparam logic [8:0] UNITS_FULL = 9'h100;
   localparam logic [7:0] OC_RESET = 8'h00;
   localparam logic [15:0] SQE_RESET = 16'h0000;
   localparam logic [15:0] DISP_RESET = 16'h0000;

   typedef enum logic [1:0] {MD_NORMAL = 2'b00, MD_REPEAT = 2'b01, MD_BLOCK = 2'b10} itdt_mode_t;
   typedef enum logic [1:0] {AM_FIXED = 2'b00, AM_INC = 2'b10, AM_DEC = 2'b11} itdt_am_t;
   typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10} itdt_size_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b011,
      ST_STEP = 3'b100,
      ST_SAVE = 3'b101
   } itdt_state_t;

   typedef struct packed {
      logic [7:0] mode_a;
      logic [7:0] mode_b;
      logic [7:0] mode_c;
      logic [31:0] src;
      logic [31:0] dst;
      logic [15:0] transfer_count_a;
      logic [15:0] block_count_b;
   } itdt_info_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } itdt_mem_req_t;
endpackage : itdt_pkg

// [itdt_transfer_controller.sv]
// Interrupt-triggered transfer controller: channels, transfer engine and register port
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module itdt_transfer_controller #(
   parameter int CHW = itdt_pkg::CH_IDX_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [itdt_pkg::REG_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   input wire logic act_valid,
   input wire logic [CHW-1:0] act_ch,
   output logic act_ready,
   output itdt_pkg::itdt_mem_req_t mem_o,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   output logic cpu_irq_req,
   output logic [CHW-1:0] cpu_irq_ch,
   output logic elc_req,
   output logic busy
);
   localparam int NCH = 1 << CHW;

   function automatic logic [31:0] unit_bytes(input logic [1:0] sz);
      unit_bytes = 32'h0000_0001 << sz;
   endfunction : unit_bytes

   function automatic logic [31:0] addr_step(input logic [31:0] a, input logic [1:0] md, input logic [31:0] amt);
      case (md)
         itdt_pkg::AM_INC: addr_step = a + amt;
         itdt_pkg::AM_DEC: addr_step = a - amt;
         default: addr_step = a;
      endcase
   endfunction : addr_step

   function automatic logic [8:0] count8(input logic [7:0] v);
      count8 = (v == 8'h00) ? itdt_pkg::UNITS_FULL : {1'b0, v};
   endfunction : count8

   function automatic logic [31:0] map_addr(input logic [31:0] a, input logic short_mode);
      map_addr = short_mode ? {{8{a[itdt_pkg::SHORT_SIGN_BIT]}}, a[itdt_pkg::SHORT_SIGN_BIT:0]} : a;
   endfunction : map_addr

   itdt_pkg::itdt_info_t info_r [NCH];
   itdt_pkg::itdt_info_t work_r;
   itdt_pkg::itdt_state_t state_r;
   logic [CHW-1:0] ch_r;
   logic [31:0] data_r;
   logic [31:0] vbr_r;
   logic [31:0] ibr_r;
   logic [7:0] opc_r;
   logic [15:0] sqe_r;
   logic [15:0] disp_r;
   logic skip_r;
   logic [CHW-1:0] last_ch_r;
   logic last_ok_r;
   logic seq_run_r;
   logic seq_susp_r;
   logic seq_first_r;
   logic [CHW-1:0] seq_resume_r;
   logic [CHW-1:0] seq_next_r;
   logic seq_next_ok_r;
   logic cpu_irq_req_r;
   logic [CHW-1:0] cpu_irq_ch_r;
   logic elc_req_r;
   logic [31:0] reg_rdata_r;

   // Decoded fields of the working copy
   logic [1:0] wmode;
   logic [1:0] wsize;
   logic [1:0] wsam;
   logic [1:0] wdam;
   logic [7:0] cra_l;
   logic [7:0] cra_h;
   logic [31:0] step;
   logic [31:0] span;
   logic [31:0] disp_ext;
   logic [31:0] src_nxt;
   logic [31:0] dst_nxt;
   logic end_unit;
   logic hit;
   logic chain_go;
   logic [CHW-1:0] ch_next;
   logic accept;
   logic start_seq;
   logic [CHW-1:0] start_ch;
   logic is_ch;
   logic [CHW-1:0] reg_ch;
   logic [4:0] reg_ofs;

   assign wmode = work_r.mode_a[itdt_pkg::MA_MODE_LSB +: 2];
   assign wsize = work_r.mode_a[itdt_pkg::MA_SIZE_LSB +: 2];
   assign wsam = work_r.mode_a[itdt_pkg::MA_SRC_AM_LSB +: 2];
   assign wdam = work_r.mode_b[itdt_pkg::MB_DST_AM_LSB +: 2];
   assign cra_l = work_r.transfer_count_a[7:0];
   assign cra_h = work_r.transfer_count_a[15:8];
   assign step = unit_bytes(wsize);
   assign span = {23'h000000, count8(cra_h)} << wsize;
   assign disp_ext = {{16{disp_r[15]}}, disp_r};
   assign src_nxt = addr_step(work_r.src, wsam, step) + (work_r.mode_a[itdt_pkg::MA_DISP_EN] ? disp_ext : 32'h0);
   assign dst_nxt = addr_step(work_r.dst, wdam, step);
   // A block ends when its unit counter leaves one; other modes end per unit
   assign end_unit = (wmode == itdt_pkg::MD_BLOCK) ? (cra_l == 8'h01) : 1'b1;
   always_comb begin
      case (wmode)
         itdt_pkg::MD_REPEAT: hit = (cra_l == 8'h01);
         itdt_pkg::MD_BLOCK: hit = (work_r.block_count_b == 16'h0001);
         default: hit = (work_r.transfer_count_a == 16'h0001);
      endcase
   end
   assign chain_go = work_r.mode_b[itdt_pkg::MB_CHAIN_EN] && (!work_r.mode_b[itdt_pkg::MB_CHAIN_SEL] || hit);
   assign ch_next = seq_next_ok_r ? seq_next_r : ch_r + 1'b1;

   assign act_ready = (state_r == itdt_pkg::ST_IDLE) && !opc_r[itdt_pkg::OC_STOP];
   assign accept = act_valid && act_ready;
   assign start_seq = sqe_r[itdt_pkg::SQ_EN] && (act_ch == sqe_r[itdt_pkg::SQ_TRIG_LSB +: CHW]);
   assign start_ch = (start_seq && seq_susp_r) ? seq_resume_r : act_ch;

   assign is_ch = (reg_addr[11:8] == itdt_pkg::CH_WIN_TAG);
   assign reg_ch = reg_addr[itdt_pkg::CH_SEL_LSB +: CHW];
   assign reg_ofs = reg_addr[4:0];

   // Transfer sequencing
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= itdt_pkg::ST_IDLE;
         ch_r <= '0;
         skip_r <= 1'b0;
      end else begin
         unique case (state_r)
            itdt_pkg::ST_IDLE: begin
               if (accept && !info_r[act_ch].mode_c[itdt_pkg::MC_FORWARD]) begin
                  ch_r <= start_ch;
                  skip_r <= opc_r[itdt_pkg::OC_READ_SKIP] && last_ok_r && (last_ch_r == start_ch);
                  state_r <= itdt_pkg::ST_LOAD;
               end
            end
            itdt_pkg::ST_LOAD: state_r <= itdt_pkg::ST_READ;
            itdt_pkg::ST_READ: if (mem_ack) state_r <= itdt_pkg::ST_WRITE;
            itdt_pkg::ST_WRITE: if (mem_ack) state_r <= itdt_pkg::ST_STEP;
            itdt_pkg::ST_STEP: state_r <= end_unit ? itdt_pkg::ST_SAVE : itdt_pkg::ST_READ;
            itdt_pkg::ST_SAVE: begin
               skip_r <= 1'b0;
               if (seq_run_r && work_r.mode_b[itdt_pkg::MB_SEQ_END]) begin
                  state_r <= itdt_pkg::ST_IDLE;
               end else if (chain_go) begin
                  ch_r <= ch_next;
                  state_r <= itdt_pkg::ST_LOAD;
               end else begin
                  state_r <= itdt_pkg::ST_IDLE;
               end
            end
            default: state_r <= itdt_pkg::ST_IDLE;
         endcase
      end
   end

   // Working copy of the active channel's transfer information
   always_ff @(posedge clk) begin
      if (rst) begin
         work_r <= '0;
         data_r <= '0;
      end else begin
         if (state_r == itdt_pkg::ST_LOAD && !skip_r) begin
            work_r <= info_r[ch_r];
         end
         if (state_r == itdt_pkg::ST_READ && mem_ack) begin
            data_r <= mem_rdata;
         end
         if (state_r == itdt_pkg::ST_STEP) begin
            work_r.src <= src_nxt;
            work_r.dst <= dst_nxt;
            unique case (wmode)
               itdt_pkg::MD_REPEAT: begin
                  work_r.transfer_count_a[7:0] <= (cra_l == 8'h01) ? cra_h : cra_l - 8'h01;
                  if (cra_l == 8'h01) begin
                     if (work_r.mode_b[itdt_pkg::MB_RPT_SRC]) work_r.src <= addr_step(src_nxt, wsam, -span);
                     else work_r.dst <= addr_step(dst_nxt, wdam, -span);
                  end
               end
               itdt_pkg::MD_BLOCK: begin
                  work_r.transfer_count_a[7:0] <= end_unit ? cra_h : cra_l - 8'h01;
                  if (end_unit) begin
                     work_r.block_count_b <= work_r.block_count_b - 16'h0001;
                     if (work_r.mode_b[itdt_pkg::MB_RPT_SRC]) work_r.src <= addr_step(src_nxt, wsam, -span);
                     else work_r.dst <= addr_step(dst_nxt, wdam, -span);
                  end
               end
               default: work_r.transfer_count_a <= work_r.transfer_count_a - 16'h0001;
            endcase
         end
      end
   end

   // Sequence tracking
   always_ff @(posedge clk) begin
      if (rst) begin
         seq_run_r <= 1'b0;
         seq_susp_r <= 1'b0;
         seq_first_r <= 1'b0;
         seq_resume_r <= '0;
         seq_next_r <= '0;
         seq_next_ok_r <= 1'b0;
      end else begin
         if (state_r == itdt_pkg::ST_IDLE && accept && start_seq) begin
            seq_run_r <= 1'b1;
            seq_first_r <= !seq_susp_r;
            seq_next_ok_r <= 1'b0;
         end
         if (state_r == itdt_pkg::ST_READ && mem_ack && seq_run_r && seq_first_r) begin
            seq_first_r <= 1'b0;
            if (work_r.mode_b[itdt_pkg::MB_INDEX_REF]) begin
               seq_next_r <= mem_rdata[CHW-1:0];
               seq_next_ok_r <= 1'b1;
            end
         end
         if (state_r == itdt_pkg::ST_SAVE) begin
            if (chain_go) seq_next_ok_r <= 1'b0;
            if (seq_run_r && work_r.mode_b[itdt_pkg::MB_SEQ_END]) begin
               seq_run_r <= 1'b0;
               seq_susp_r <= 1'b0;
            end else if (seq_run_r && !chain_go) begin
               seq_run_r <= 1'b0;
               seq_susp_r <= 1'b1;
               seq_resume_r <= ch_next;
            end
         end
      end
   end

   // Stored transfer information: software writes and engine write-back
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) info_r[i] <= '0;
         last_ok_r <= 1'b0;
         last_ch_r <= '0;
      end else begin
         if (state_r == itdt_pkg::ST_SAVE) begin
            last_ok_r <= 1'b1;
            last_ch_r <= ch_r;
            if (!work_r.mode_a[itdt_pkg::MA_WB_DISABLE]) begin
               info_r[ch_r].transfer_count_a <= work_r.transfer_count_a;
               info_r[ch_r].block_count_b <= work_r.block_count_b;
               if (wsam != itdt_pkg::AM_FIXED) info_r[ch_r].src <= work_r.src;
               if (wdam != itdt_pkg::AM_FIXED) info_r[ch_r].dst <= work_r.dst;
            end
         end
         if (reg_we && is_ch) begin
            last_ok_r <= 1'b0;
            case (reg_ofs)
               itdt_pkg::CH_MODE_A: info_r[reg_ch].mode_a <= reg_wdata[7:0];
               itdt_pkg::CH_MODE_B: info_r[reg_ch].mode_b <= reg_wdata[7:0];
               itdt_pkg::CH_MODE_C: info_r[reg_ch].mode_c <= reg_wdata[7:0];
               itdt_pkg::CH_SRC: info_r[reg_ch].src <= reg_wdata;
               itdt_pkg::CH_DST: info_r[reg_ch].dst <= reg_wdata;
               itdt_pkg::CH_CRA: info_r[reg_ch].transfer_count_a <= reg_wdata[15:0];
               itdt_pkg::CH_CRB: info_r[reg_ch].block_count_b <= reg_wdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // Global registers
   always_ff @(posedge clk) begin
      if (rst) begin
         vbr_r <= '0;
         ibr_r <= '0;
         opc_r <= itdt_pkg::OC_RESET;
         sqe_r <= itdt_pkg::SQE_RESET;
         disp_r <= itdt_pkg::DISP_RESET;
      end else if (reg_we && !is_ch) begin
         case (reg_addr)
            itdt_pkg::OFS_VECTOR_BASE: vbr_r <= {{4{reg_wdata[itdt_pkg::VBR_SIGN_BIT]}},
               reg_wdata[itdt_pkg::VBR_SIGN_BIT:itdt_pkg::VBR_ZERO_W], {itdt_pkg::VBR_ZERO_W{1'b0}}};
            itdt_pkg::OFS_INDEX_BASE: ibr_r <= reg_wdata;
            itdt_pkg::OFS_OP_CTRL: opc_r <= reg_wdata[7:0];
            itdt_pkg::OFS_SEQ_ENABLE: sqe_r <= reg_wdata[15:0];
            itdt_pkg::OFS_DISP: disp_r <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata_r <= '0;
      end else begin
         reg_rdata_r <= '0;
         if (reg_re && is_ch) begin
            case (reg_ofs)
               itdt_pkg::CH_MODE_A: reg_rdata_r <= {24'h000000, info_r[reg_ch].mode_a};
               itdt_pkg::CH_MODE_B: reg_rdata_r <= {24'h000000, info_r[reg_ch].mode_b};
               itdt_pkg::CH_MODE_C: reg_rdata_r <= {24'h000000, info_r[reg_ch].mode_c};
               itdt_pkg::CH_SRC: reg_rdata_r <= info_r[reg_ch].src;
               itdt_pkg::CH_DST: reg_rdata_r <= info_r[reg_ch].dst;
               itdt_pkg::CH_CRA: reg_rdata_r <= {16'h0000, info_r[reg_ch].transfer_count_a};
               itdt_pkg::CH_CRB: reg_rdata_r <= {16'h0000, info_r[reg_ch].block_count_b};
               default: reg_rdata_r <= '0;
            endcase
         end else if (reg_re) begin
            case (reg_addr)
               itdt_pkg::OFS_VECTOR_BASE: reg_rdata_r <= vbr_r;
               itdt_pkg::OFS_INDEX_BASE: reg_rdata_r <= ibr_r;
               itdt_pkg::OFS_OP_CTRL: reg_rdata_r <= {24'h000000, opc_r};
               itdt_pkg::OFS_SEQ_ENABLE: reg_rdata_r <= {16'h0000, sqe_r};
               itdt_pkg::OFS_DISP: reg_rdata_r <= {16'h0000, disp_r};
               itdt_pkg::OFS_STATUS: reg_rdata_r <= {16'h0000, 5'h00, seq_run_r, seq_susp_r,
                  1'b0, 5'(ch_r), 3'(state_r)};
               default: reg_rdata_r <= '0;
            endcase
         end
      end
   end

   // Outgoing interrupt and event link pulses
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_irq_req_r <= 1'b0;
         cpu_irq_ch_r <= '0;
         elc_req_r <= 1'b0;
      end else begin
         cpu_irq_req_r <= 1'b0;
         elc_req_r <= 1'b0;
         if (state_r == itdt_pkg::ST_IDLE && accept && info_r[act_ch].mode_c[itdt_pkg::MC_FORWARD]) begin
            cpu_irq_req_r <= 1'b1;
            cpu_irq_ch_r <= act_ch;
         end
         if (state_r == itdt_pkg::ST_STEP && end_unit) begin
            elc_req_r <= 1'b1;
            if (work_r.mode_b[itdt_pkg::MB_IRQ_EACH] || hit) begin
               cpu_irq_req_r <= 1'b1;
               cpu_irq_ch_r <= ch_r;
            end
         end
      end
   end

   always_comb begin
      mem_o.req = (state_r == itdt_pkg::ST_READ) || (state_r == itdt_pkg::ST_WRITE);
      mem_o.we = (state_r == itdt_pkg::ST_WRITE);
      mem_o.size = wsize;
      mem_o.addr = map_addr((state_r == itdt_pkg::ST_WRITE) ? work_r.dst : work_r.src, opc_r[itdt_pkg::OC_SHORT]);
      mem_o.wdata = data_r;
   end

   assign reg_rdata = reg_rdata_r;
   assign cpu_irq_req = cpu_irq_req_r;
   assign cpu_irq_ch = cpu_irq_ch_r;
   assign elc_req = elc_req_r;
   assign busy = (state_r != itdt_pkg::ST_IDLE);

   property p_normal_one;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_STEP && wmode == itdt_pkg::MD_NORMAL) |=> (state_r == itdt_pkg::ST_SAVE);
   endproperty
   a_normal_one: assert property (p_normal_one) else $error("normal mode moved more than one unit");

   property p_normal_dec;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_STEP && wmode == itdt_pkg::MD_NORMAL) |=> (work_r.transfer_count_a == $past(work_r.transfer_count_a) - 16'h0001);
   endproperty
   a_normal_dec: assert property (p_normal_dec) else $error("counter did not decrement by one");

   property p_repeat_reload;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_STEP && wmode == itdt_pkg::MD_REPEAT && cra_l == 8'h01) |=> (cra_l == cra_h);
   endproperty
   a_repeat_reload: assert property (p_repeat_reload) else $error("repeat counter not reloaded");

   property p_block_loop;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_STEP && wmode == itdt_pkg::MD_BLOCK && cra_l != 8'h01)
         |=> (state_r == itdt_pkg::ST_READ && mem_o.req && !mem_o.we);
   endproperty
   a_block_loop: assert property (p_block_loop) else $error("block ended early");

   property p_event_link;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_STEP) |=> (elc_req == $past(end_unit));
   endproperty
   a_event_link: assert property (p_event_link) else $error("event link pulse wrong");

   property p_chain_always;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_SAVE && !seq_run_r && work_r.mode_b[itdt_pkg::MB_CHAIN_EN]
         && !work_r.mode_b[itdt_pkg::MB_CHAIN_SEL]) |=> (state_r == itdt_pkg::ST_LOAD);
   endproperty
   a_chain_always: assert property (p_chain_always) else $error("chain not taken");

   property p_short_space;
      @(posedge clk) disable iff (rst)
      (mem_o.req && opc_r[itdt_pkg::OC_SHORT]) |-> (mem_o.addr[31:23] == 9'h000 || mem_o.addr[31:23] == 9'h1FF);
   endproperty
   a_short_space: assert property (p_short_space) else $error("short address outside its space");

   property p_wb_disable;
      @(posedge clk) disable iff (rst)
      (state_r == itdt_pkg::ST_SAVE && work_r.mode_a[itdt_pkg::MA_WB_DISABLE] && !reg_we)
         |=> (info_r[$past(ch_r)] == $past(info_r[ch_r]));
   endproperty
   a_wb_disable: assert property (p_wb_disable) else $error("write-back happened while disabled");

   property p_vbr_read;
      @(posedge clk) disable iff (rst)
      (reg_re && reg_addr == itdt_pkg::OFS_VECTOR_BASE)
         |=> (reg_rdata[9:0] == 10'h000 && reg_rdata[31:28] == {4{reg_rdata[27]}});
   endproperty
   a_vbr_read: assert property (p_vbr_read) else $error("vector base read malformed");

   property p_stop;
      @(posedge clk) disable iff (rst)
      opc_r[itdt_pkg::OC_STOP] && (state_r == itdt_pkg::ST_IDLE) |=> (state_r == itdt_pkg::ST_IDLE);
   endproperty
   a_stop: assert property (p_stop) else $error("request taken in module stop");
endmodule : itdt_transfer_controller

// [itdt_mem_model.sv]
// Memory model answering the transfer engine's bus requests
`timescale 1ns/10ps
module itdt_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire itdt_pkg::itdt_mem_req_t mem_o,
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   logic [1:0] wait_r;
   logic [31:0] pat;
   always_ff @(posedge clk) begin
      if (rst || mem_ack || !mem_o.req) begin
         wait_r <= 2'h0;
      end else begin
         wait_r <= wait_r + 2'h1;
      end
   end
   assign mem_ack = mem_o.req && (!slow || wait_r == 2'h2);
   assign pat = mem_o.addr ^ 32'h5A5A_0000;
   // Outside the answer the data lines show the inverse
   assign mem_rdata = mem_ack ? pat : ~pat;
endmodule : itdt_mem_model

// [interrupt_triggered_data_transfer_tb_top.sv]
// Testbench: register access, normal and block transfers
`timescale 1ns/10ps
module interrupt_triggered_data_transfer_tb_top;
   logic clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, act_valid = 1'b0, slow = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_rdata, wa, wd;
   logic [2:0] act_ch = 3'h0, irq_ch;
   logic act_ready, mem_ack, irq, elc, busy;
   itdt_pkg::itdt_mem_req_t mem_o;
   int num_errors = 0, tests_run = 0, cycles = 0, n_wr = 0, n_elc = 0, n_irq = 0;
   always #5 clk = ~clk;
   itdt_transfer_controller i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .act_valid(act_valid), .act_ch(act_ch),
      .act_ready(act_ready), .mem_o(mem_o), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .cpu_irq_req(irq), .cpu_irq_ch(irq_ch), .elc_req(elc), .busy(busy));
   itdt_mem_model i_mem (.clk(clk), .rst(rst), .slow(slow), .mem_o(mem_o), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cycles++;
      if (mem_ack === 1'b1 && mem_o.we === 1'b1) begin
         n_wr++;
         wa = mem_o.addr;
         wd = mem_o.wdata;
      end
      if (elc === 1'b1) n_elc++;
      if (irq === 1'b1) n_irq++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask : rdc
   task automatic fire(input logic [2:0] ch);
      @(posedge clk);
      act_valid <= 1'b1;
      act_ch <= ch;
      @(negedge clk);
      while (act_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      act_valid <= 1'b0;
      @(negedge clk);
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
      repeat (2) @(posedge clk);
   endtask : fire
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(12'h008, 32'h0);
      rdc(12'hFF0, 32'h0);
      wr(12'h000, 32'hFFFF_FFFF);
      rdc(12'h000, 32'hFFFF_FC00);
      wr(12'h000, 32'h7000_0400);
      rdc(12'h000, 32'h0000_0400);
      // Module stop: a pending request must not be taken
      wr(12'h008, 32'h1);
      @(posedge clk);
      act_valid <= 1'b1;
      act_ch <= 3'h1;
      repeat (3) @(posedge clk);
      #1 check(32'(busy), 32'h0);
      check(32'(act_ready), 32'h0);
      @(posedge clk);
      act_valid <= 1'b0;
      wr(12'h008, 32'h0);
      $display("Test registers done");
      // Channel 1: normal mode, word units, both addresses incrementing, count 2
      wr(12'h120, 32'h28);
      wr(12'h124, 32'h20);
      wr(12'h12C, 32'h1000);
      wr(12'h130, 32'h2000);
      wr(12'h134, 32'h2);
      wr(12'h138, 32'h5);
      fire(3'h1);
      check(32'(n_wr), 32'h1);
      check(wa, 32'h2000);
      check(wd, 32'h5A5A_1000);
      check(32'(n_elc), 32'h1);
      check(32'(n_irq), 32'h0);
      rdc(12'h12C, 32'h1004);
      rdc(12'h134, 32'h1);
      slow <= 1'b1;
      fire(3'h1);
      check(wa, 32'h2004);
      check(32'(n_irq), 32'h1);
      check(32'(irq_ch), 32'h1);
      wr(12'h134, 32'h5);
      wr(12'h120, 32'h29);
      fire(3'h1);
      check(wa, 32'h2008);
      rdc(12'h12C, 32'h1008);
      rdc(12'h134, 32'h5);
      $display("Test normal done");
      // Channel 3: repeat mode, repeat size one, destination area restored
      wr(12'h160, 32'h68);
      wr(12'h164, 32'h20);
      wr(12'h16C, 32'h5000);
      wr(12'h170, 32'h6000);
      wr(12'h174, 32'h0101);
      fire(3'h3);
      fire(3'h3);
      check(wa, 32'h6000);
      check(wd, 32'h5A5A_5004);
      $display("Test repeat done");
      // Channel 2: block mode, three words in one request
      wr(12'h140, 32'hA8);
      wr(12'h144, 32'h20);
      wr(12'h14C, 32'h4000);
      wr(12'h150, 32'h3000);
      wr(12'h154, 32'h0303);
      wr(12'h158, 32'h1);
      n_wr = 0;
      n_elc = 0;
      fire(3'h2);
      check(32'(n_wr), 32'h3);
      check(32'(n_elc), 32'h1);
      check(wa, 32'h3008);
      check(wd, 32'h5A5A_4008);
      $display("Test block done");
      conclude();
   end
endmodule : interrupt_triggered_data_transfer_tb_top
